/* verilog/eeprom_ctl_cfg.svh */
`ifndef EEPROM_CTL_CFG_SVH
`define EEPROM_CTL_CFG_SVH

// Fixed device code and internal slave-select bits
`define DEV_CODE        4'ha
`define SLAVE_SEL       3'h0

// Clock and filter timing
`define CLK_PERIOD_NS   20
`define GLITCH_NS       50
`define FILT_CYC        ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Write inhibit hold after power-on reset release, in cycles
`define POR_HOLD_CYC    1000

// Dummy clock count of the interface reset sequence
`define RST_CLKS        4'h9
// SCL rises seen before the closing start: the dummy clocks plus the rise that frames that start
`define RST_RISES       (`RST_CLKS + 4'h1)

// Bit counts
`define BYTE_BITS       4'h8
`define ADDR_SHIFT_LSB  1

`endif

/* verilog/eeprom_ctl_pkg.sv */
package eeprom_ctl_pkg;

  // Serial engine phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } ser_state_t;

endpackage

/* verilog/serial_eeprom_reset_protect.sv */
`timescale 1ns/1ps
`include "eeprom_ctl_cfg.svh"

module serial_eeprom_reset_protect #(
  parameter int POR_HOLD = `POR_HOLD_CYC  // Write inhibit cycles after reset
) (
  input  wire logic       ref_clk,      // System clock, 50 MHz
  input  wire logic       nrst,         // Async reset, active low
  input  wire logic       scl_i,        // SCL pin level
  input  wire logic       sda_i,        // SDA pin level
  output logic            sda_o,        // SDA drive value, always low
  output logic            sda_oe,       // SDA pull-down enable
  input  wire logic       wp_i,         // Write-protect pin
  input  wire logic       low_supply_i, // Supply monitor: at or below threshold
  input  wire logic       write_busy_i, // Nonvolatile write cycle running
  input  wire logic [7:0] tx_data_i,    // Read byte from array side
  output logic            tx_req,       // Pulse: tx_data_i taken
  output logic [7:0]      rx_byte,      // Last received data byte
  output logic            rx_valid,     // Pulse: rx_byte updated
  output logic            addr_rw,      // Read/write bit of matched address
  output logic            addr_hit,     // Pulse: own address acknowledged
  output logic            write_start,  // Pulse: begin nonvolatile write
  output logic            sw_reset      // Pulse: interface reset sequence seen
);

  if (POR_HOLD < 1 || POR_HOLD > 65535) begin : g_bad_hold
    $error("POR_HOLD out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and glitch filters
  logic [1:0] pin_in;
  wire  [1:0] filt_r;
  assign pin_in = {sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_line
      logic       s1_r;
      logic       s2_r;
      logic [2:0] cnt_r;
      logic       flt_r;
      // Two flops before anything looks at the pin
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
        end else begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
        end
      end
      // A change must persist past the glitch window before it is accepted
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          cnt_r      <= 3'h0;
          flt_r      <= 1'b1;
        end else if (s2_r == flt_r) begin
          cnt_r <= 3'h0;
        end else if (cnt_r == 3'(`FILT_CYC)) begin
          flt_r      <= s2_r;
          cnt_r      <= 3'h0;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end
      assign filt_r[gi] = flt_r;
    end
  endgenerate

  // Other level inputs, synchronised
  logic [2:0] lvl_s1_r;
  logic [2:0] lvl_s2_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lvl_s1_r <= 3'h3;
      lvl_s2_r <= 3'h3;
    end else begin
      lvl_s1_r <= {write_busy_i, low_supply_i, wp_i};
      lvl_s2_r <= lvl_s1_r;
    end
  end

  wire wp_s    = lvl_s2_r[0];
  wire low_s   = lvl_s2_r[1];
  wire busy_s  = lvl_s2_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Bus event decode
  logic scl_d_r;
  logic sda_d_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= filt_r[0];
      sda_d_r <= filt_r[1];
    end
  end

  wire scl_f    = filt_r[0];
  wire sda_f    = filt_r[1];
  wire scl_rise = scl_f & ~scl_d_r;
  wire scl_fall = ~scl_f & scl_d_r;
  wire start_ev = scl_f & scl_d_r & sda_d_r & ~sda_f;
  wire stop_ev  = scl_f & scl_d_r & ~sda_d_r & sda_f;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on write inhibit
  logic [15:0] por_cnt_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      por_cnt_r <= 16'h0;
    end else if (por_cnt_r != 16'(POR_HOLD)) begin
      por_cnt_r <= por_cnt_r + 16'h1;
    end
  end
  wire por_done = (por_cnt_r == 16'(POR_HOLD));

  ////////////////////////////////////////////////////////////////////////////
  // Interface reset sequence detector: counts clocks after a start
  logic [3:0] rst_clk_r;
  logic       rst_arm_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_arm_r <= 1'b0;
      rst_clk_r <= 4'h0;
    end else if (start_ev) begin
      rst_arm_r <= ~busy_s;
      rst_clk_r <= 4'h0;
    end else if (stop_ev) begin
      rst_arm_r <= 1'b0;
    end else if (scl_rise && rst_arm_r && rst_clk_r != 4'hf) begin
      rst_clk_r <= rst_clk_r + 4'h1;
    end
  end
  // Busy device ignores the sequence entirely
  wire sw_rst_hit = start_ev & rst_arm_r & ~busy_s & (rst_clk_r == `RST_RISES);

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine

  eeprom_ctl_pkg::ser_state_t state_r;
  eeprom_ctl_pkg::ser_state_t state_nxt;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic       oe_r;
  logic       rw_r;
  logic       got_byte_r;
  logic       wp_seen_r;
  logic       nack_r;

  wire addr_match = (sh_r[7:4] == `DEV_CODE) && (sh_r[3:1] == `SLAVE_SEL);
  wire in_write   = (state_r == eeprom_ctl_pkg::ST_WDATA) || (state_r == eeprom_ctl_pkg::ST_WACK);
  wire write_ok   = stop_ev & in_write & got_byte_r & ~wp_seen_r & ~wp_s & ~low_s & por_done;
  wire byte_end   = scl_fall & (bit_r == `BYTE_BITS);

  // Next phase; a start reopens addressing unless busy (then idle), so a half command is dropped
  always_comb begin
    state_nxt = state_r;
    if (start_ev) begin
      state_nxt = busy_s ? eeprom_ctl_pkg::ST_IDLE : eeprom_ctl_pkg::ST_ADDR;
    end else if (stop_ev || busy_s) begin
      state_nxt = eeprom_ctl_pkg::ST_IDLE;
    end else begin
      case (state_r)
        eeprom_ctl_pkg::ST_ADDR:  if (byte_end) state_nxt = addr_match ? eeprom_ctl_pkg::ST_AACK
                                                                       : eeprom_ctl_pkg::ST_IDLE;
        eeprom_ctl_pkg::ST_AACK:  if (scl_fall) state_nxt = rw_r ? eeprom_ctl_pkg::ST_RDATA
                                                                 : eeprom_ctl_pkg::ST_WDATA;
        eeprom_ctl_pkg::ST_WDATA: if (byte_end) state_nxt = eeprom_ctl_pkg::ST_WACK;
        eeprom_ctl_pkg::ST_WACK:  if (scl_fall) state_nxt = eeprom_ctl_pkg::ST_WDATA;
        eeprom_ctl_pkg::ST_RDATA: if (byte_end) state_nxt = eeprom_ctl_pkg::ST_RACK;
        eeprom_ctl_pkg::ST_RACK:  if (scl_fall) state_nxt = nack_r ? eeprom_ctl_pkg::ST_IDLE
                                                                   : eeprom_ctl_pkg::ST_RDATA;
        default:                  state_nxt = state_r;
      endcase
    end
  end

  wire load_tx = ~start_ev & ~stop_ev & ~busy_s & scl_fall & (
                 ((state_r == eeprom_ctl_pkg::ST_AACK) & rw_r) |
                 ((state_r == eeprom_ctl_pkg::ST_RACK) & ~nack_r));
  wire rx_done = ~start_ev & ~stop_ev & ~busy_s & byte_end & (state_r == eeprom_ctl_pkg::ST_WDATA);
  wire a_done  = ~start_ev & ~stop_ev & ~busy_s & byte_end & (state_r == eeprom_ctl_pkg::ST_ADDR) & addr_match;

  // Phase register and bit counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= eeprom_ctl_pkg::ST_IDLE;
      bit_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || start_ev) begin
        bit_r <= 4'h0;
      end else if (scl_rise) begin
        bit_r <= bit_r + 4'h1;
      end
    end
  end

  // Shifting and per-transaction flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sh_r       <= 8'h00;
      tx_r       <= 8'h00;
      rw_r       <= 1'b0;
      nack_r     <= 1'b0;
      got_byte_r <= 1'b0;
      wp_seen_r  <= 1'b0;
    end else begin
      if (scl_rise) begin
        sh_r   <= {sh_r[6:0], sda_f};
        nack_r <= sda_f;
      end
      if (a_done) begin
        rw_r <= sh_r[0];
      end
      if (load_tx) begin
        tx_r <= tx_data_i;
      end else if (scl_fall && state_r == eeprom_ctl_pkg::ST_RDATA) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
      // Protect pin must stay low for the whole transaction
      if (start_ev) begin
        got_byte_r <= 1'b0;
        wp_seen_r  <= wp_s;
      end else begin
        got_byte_r <= got_byte_r | rx_done;
        wp_seen_r  <= wp_seen_r | wp_s;
      end
    end
  end

  // SDA pull-down: acks and read zeros, even mid reset sequence
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oe_r <= 1'b0;
    end else if (start_ev || stop_ev || busy_s) begin
      oe_r <= 1'b0;
    end else if (a_done || rx_done) begin
      oe_r <= 1'b1;
    end else if (load_tx) begin
      oe_r <= ~tx_data_i[7];
    end else if (scl_fall && state_r == eeprom_ctl_pkg::ST_RDATA) begin
      oe_r <= (bit_r == `BYTE_BITS) ? 1'b0 : ~tx_r[6];
    end else if (scl_fall && state_r != eeprom_ctl_pkg::ST_ADDR && state_r != eeprom_ctl_pkg::ST_WDATA) begin
      oe_r <= 1'b0;
    end
  end

  // Registered output strobes and data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_byte     <= 8'h00;
      rx_valid    <= 1'b0;
      addr_hit    <= 1'b0;
      tx_req      <= 1'b0;
      write_start <= 1'b0;
      sw_reset    <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_byte <= sh_r;
      end
      rx_valid    <= rx_done;
      addr_hit    <= a_done;
      tx_req      <= load_tx;
      write_start <= write_ok;
      sw_reset    <= sw_rst_hit;
    end
  end

  assign sda_o   = 1'b0;
  assign sda_oe  = oe_r;
  assign addr_rw = rw_r;

endmodule

/* tb/eeprom_chk.sv */
`timescale 1ns/1ps
// Pin and pulse checks for the protect block
module eeprom_chk #(
  parameter int POR_HOLD = 10 // Inhibit cycles
) (
  input wire logic       ref_clk, // Clock
  input wire logic       nrst, // Reset
  input wire logic       scl_i, // SCL
  input wire logic       sda_i, // SDA
  input wire logic       sda_o, // Drive value
  input wire logic       sda_oe, // Pull enable
  input wire logic       wp_i, // Protect
  input wire logic       low_supply_i, // Low supply
  input wire logic       write_busy_i, // Busy
  input wire logic [7:0] tx_data_i, // Read byte
  input wire logic       tx_req, // Byte taken
  input wire logic [7:0] rx_byte, // Rx byte
  input wire logic       rx_valid, // Rx pulse
  input wire logic       addr_rw, // R/W bit
  input wire logic       addr_hit, // Address ack
  input wire logic       write_start, // Write pulse
  input wire logic       sw_reset // Reset pulse
);
  // Cycles since release; saturates so it never wraps back under the hold
  logic [15:0] por_cnt_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) por_cnt_r <= 16'h0000;
    else if (por_cnt_r != 16'hffff) por_cnt_r <= por_cnt_r + 16'h0001;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Inputs pass two sync flops first, so a level must stand a few cycles
  sequence s_busy; write_busy_i [*5]; endsequence
  sequence s_ack; sda_oe [*2]; endsequence
  a_busy_no_ack: assert property (s_busy |-> !sda_oe && !addr_hit)
    else $error("ack while busy");
  a_busy_no_reset: assert property (s_busy |-> !sw_reset)
    else $error("reset while busy");
  a_wp_no_write: assert property (wp_i [*5] |-> !write_start)
    else $error("write while protected");
  a_low_no_write: assert property (low_supply_i [*5] |-> !write_start)
    else $error("write at low supply");
  a_por_no_write: assert property (write_start |-> por_cnt_r >= POR_HOLD - 1)
    else $error("write inside power-on hold");
  a_oe_scl_low: assert property ($rose(sda_oe) |-> !scl_i && !sda_o)
    else $error("pull began with SCL high");
  a_hit_acks: assert property (addr_hit |-> s_ack)
    else $error("address hit without ack");
  a_reset_idle: assert property (sw_reset |=> !sda_oe [*3])
    else $error("drive after reset sequence");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind serial_eeprom_reset_protect eeprom_chk #(.POR_HOLD(POR_HOLD)) u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .low_supply_i(low_supply_i),
  .write_busy_i(write_busy_i), .tx_data_i(tx_data_i), .tx_req(tx_req), .rx_byte(rx_byte),
  .rx_valid(rx_valid), .addr_rw(addr_rw), .addr_hit(addr_hit), .write_start(write_start), .sw_reset(sw_reset));

/* tb/host_bfm.sv */
`timescale 1ns/1ps
// Bus master: makes SCL, only pulls SDA low or lets it go
module host_bfm (
  output logic      scl, // SCL
  output logic      host_low, // Pulls SDA
  input  wire logic sda // Bus level
);
  logic glitch = 1'b0; // Adds a 40 ns SCL spike
  int   slow = 0; // Extra low time per bit, ns
  // Both lines idle high from power-up
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  task automatic start();
    #80 host_low = 1'b0;
    #160 scl = 1'b1;
    #160 host_low = 1'b1;
    #160 scl = 1'b0;
  endtask
  task automatic stop();
    #80 host_low = 1'b1;
    #160 scl = 1'b1;
    #160 host_low = 1'b0;
  endtask
  // Nine slots MSB first; data moves mid-low so the slave's late ack never races SCL
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #80 host_low = !d[i];
      if (glitch && i == 4) begin
        #40 scl = 1'b1;
        #40 scl = 1'b0;
      end
      #(160 + slow) scl = 1'b1;
      #160 q[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule

/* tb/serial_eeprom_reset_protect_tb_top.sv */
`timescale 1ns/1ps
module serial_eeprom_reset_protect_tb_top;
  logic       ref_clk = 1'b0, nrst = 1'b0, wp_i = 1'b0, low_supply_i = 1'b0, write_busy_i = 1'b0;
  logic       sda_o, sda_oe, addr_hit, write_start, sw_reset, scl, host_low, ack_a, tx_req, rx_valid, addr_rw;
  logic [7:0] tx_data_i = 8'hc3, rx_byte;
  logic [7:0] bad_addr [4] = '{8'hb0, 8'ha2, 8'ha4, 8'ha8};
  logic [8:0] q;
  int         bad_count = 0, compares = 0, n_ws = 0, n_sw = 0, n_hit = 0, n_txr = 0, n_rxv = 0;
  wire        sda = !(host_low || (sda_oe && !sda_o)); // Pull-up wins when nobody pulls
  always #10 ref_clk = ~ref_clk;
  serial_eeprom_reset_protect #(.POR_HOLD(10)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .low_supply_i(low_supply_i),
    .write_busy_i(write_busy_i), .tx_data_i(tx_data_i), .tx_req(tx_req), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .addr_rw(addr_rw), .addr_hit(addr_hit), .write_start(write_start), .sw_reset(sw_reset));
  host_bfm u_host (.scl(scl), .host_low(host_low), .sda(sda));
  // Pulse tallies, taken mid-cycle where the registered outputs have settled
  always @(negedge ref_clk) begin
    n_txr += int'(tx_req === 1'b1);
    n_rxv += int'(rx_valid === 1'b1);
    n_ws += int'(write_start === 1'b1);
    n_sw += int'(sw_reset === 1'b1);
    n_hit += int'(addr_hit === 1'b1);
  end
  // Hang guard, far past the 6000 or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Address byte, one data byte, stop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.start();
    u_host.xfer({a, 1'b1}, q);
    ack_a = !q[0];
    u_host.xfer({d, 1'b1}, q);
    u_host.stop();
    repeat (20) @(negedge ref_clk);
  endtask
  task automatic rst_seq();
    u_host.start();
    u_host.xfer(9'h1ff, q);
    u_host.start();
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    rst_seq();
    check("sw_reset", n_sw, 1);
    wr(8'ha0, 8'h5a);
    check("addr_ack", ack_a, 1);
    check("rx_byte", rx_byte, 8'h5a);
    check("write", n_ws, 1);
    wp_i = 1'b1;
    wr(8'ha0, 8'h11);
    wp_i = 1'b0;
    check("wp_write", n_ws, 1);
    low_supply_i = 1'b1;
    wr(8'ha0, 8'h22);
    low_supply_i = 1'b0;
    check("low_write", n_ws, 1);
    u_host.glitch = 1'b1;
    wr(8'ha0, 8'h96);
    u_host.glitch = 1'b0;
    check("glitch_rx", rx_byte, 8'h96);
    check("glitch_write", n_ws, 2);
    foreach (bad_addr[i]) begin
      wr(bad_addr[i], 8'h33);
      check("bad_ack", ack_a, 0);
    end
    check("bad_write", n_ws, 2);
    write_busy_i = 1'b1;
    wr(8'ha0, 8'h44);
    check("busy_ack", ack_a, 0);
    rst_seq();
    check("busy_reset", n_sw, 1);
    write_busy_i = 1'b0;
    wr(8'ha0, 8'h55);
    check("poll_ack", ack_a, 1);
    check("poll_write", n_ws, 3);
    check("rx_count", n_rxv, 5);
    u_host.slow = 400;
    u_host.start();
    u_host.xfer(9'h143, q);
    check("read_ack", q[0], 0);
    check("read_rw", addr_rw, 1);
    u_host.xfer(9'h1fe, q);
    check("read_byte", q[8:1], 8'hc3);
    u_host.slow = 0;
    rst_seq();
    check("mid_reset", n_sw, 2);
    check("tx_count", n_txr, 2);
    u_host.xfer(9'h141, q);
    check("reset_ack", q[0], 0);
    check("write_rw", addr_rw, 0);
    u_host.stop();
    check("hits", n_hit, 7);
    tally_and_finish();
  end
endmodule
